/* dv/interrupt_priority_level_regs_tb.sv */
// self-checking bench for the interrupt priority level register bank
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_priority_regs.svh"

`define CHECK_EQ(what, expv, gotv) begin cmpCount++; if ((gotv) !== (expv)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", what, expv, gotv); end end

module interrupt_priority_level_regs_tb
    import interrupt_priority_pkg::*;
;
    // ****************************************
    // tables of expected layout
    // ****************************************
    localparam logic [15:0] IMPL [5] = '{16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h7077};
    localparam logic [15:0] PAT  [5] = '{16'h7531, 16'h6420, 16'h1357, 16'h0246, 16'h3012};
    localparam int          FREG [18] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 4};
    localparam int          FPOS [18] = '{12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 12, 4, 0};
    localparam logic [7:0]  ADDR [5] = '{`PRIORITY_TIMER1_OC1_IC1_EXT0_OFF, `PRIORITY_TIMER2_OC2_IC2_DMA0_OFF,
        `PRIORITY_UART1RX_SPI1_TIMER3_OFF, `PRIORITY_DMA1_ADC1_UART1TX_OFF, `PRIORITY_PINCHANGE_I2C1_OFF};

    logic        core_clk;
    logic        nrst;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic [17:0] srcFlag;
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [17:0] srcRequest;
    wire logic [2:0]  lv [18];
    int          failures;
    int          cmpCount;

    interrupt_priority_level_regs DUT (
        .core_clk(core_clk), .nrst(nrst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .srcFlag(srcFlag), .srcRequest(srcRequest),
        .timer1_level(lv[0]), .out_compare1_level(lv[1]), .in_capture1_level(lv[2]), .ext_irq0_level(lv[3]),
        .timer2_level(lv[4]), .out_compare2_level(lv[5]), .in_capture2_level(lv[6]), .dma_ch0_done_level(lv[7]),
        .uart1_receive_level(lv[8]), .spi1_event_level(lv[9]), .spi1_error_level(lv[10]), .timer3_level(lv[11]),
        .dma_ch1_done_level(lv[12]), .adc1_done_level(lv[13]), .uart1_transmit_level(lv[14]),
        .pin_change_level(lv[15]), .i2c1_master_level(lv[16]), .i2c1_slave_level(lv[17])
    );

    always #4 core_clk = ~core_clk;

    // ****************************************
    // expectations
    // ****************************************
    function automatic logic [2:0] expLevel(input int i);
        return PAT[FREG[i]][FPOS[i] +: 3];
    endfunction

    function automatic logic [17:0] expReq(input logic [17:0] f, input logic [17:0] en);
        logic [17:0] e;
        for (int i = 0; i < 18; i++) begin
            e[i] = f[i] & en[i] & (expLevel(i) != 3'h0);
        end
        return e;
    endfunction

    // ****************************************
    // reset, bus and summary tasks
    // ****************************************
    task automatic applyReset(input int n);
        nrst <= 1'h0;
        repeat (n) @(posedge core_clk);
        nrst <= 1'h1;
        @(posedge core_clk);
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        bit awDone;
        bit wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        r = 2'h3;
        s_axi_awaddr  <= {24'h000000, a};
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (s_axi_bvalid === 1'h1) begin
                r = s_axi_bresp;
                break;
            end
            if (!awDone && s_axi_awready === 1'h1) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'h0;
            end
            if (!wDone && s_axi_wready === 1'h1) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'h0;
            end
        end
        s_axi_bready <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit arDone;
        arDone = 1'b0;
        d = 32'hFFFFFFFF;
        r = 2'h3;
        s_axi_araddr  <= {24'h000000, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (arDone && s_axi_rvalid === 1'h1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
            if (!arDone && s_axi_arready === 1'h1) begin
                arDone = 1'b1;
                s_axi_arvalid <= 1'h0;
            end
        end
        s_axi_rready <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic doWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        axiWrite(a, d, s, r);
        `CHECK_EQ("write response", er, r)
    endtask

    task automatic checkRead(input string nm, input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axiRead(a, d, r);
        `CHECK_EQ(nm, ed, d)
        `CHECK_EQ("read response", er, r)
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        core_clk = 1'h0;
        failures = 0;
        cmpCount = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'h0;
        srcFlag = 18'h00000;
        applyReset(20);
        for (int r = 0; r < 5; r++) checkRead("prio reset", ADDR[r], {16'h0000, 16'h4444 & IMPL[r]}, 2'h0);
        checkRead("enable reset", `SOURCE_ENABLE_OFF, 32'h00000000, 2'h0);
        for (int i = 0; i < 18; i++) `CHECK_EQ("level reset", 3'h4, lv[i])
        for (int r = 0; r < 5; r++) begin
            doWrite(ADDR[r], 32'hFFFFFFFF, 4'hF, 2'h0);
            checkRead("prio ones", ADDR[r], {16'h0000, IMPL[r]}, 2'h0);
        end
        for (int i = 0; i < 18; i++) `CHECK_EQ("level max", 3'h7, lv[i])
        for (int r = 0; r < 5; r++) begin
            doWrite(ADDR[r], {16'hFFFF, PAT[r] | ~IMPL[r]}, 4'hF, 2'h0);
            checkRead("prio pattern", ADDR[r], {16'h0000, PAT[r]}, 2'h0);
        end
        for (int i = 0; i < 18; i++) `CHECK_EQ("level field", expLevel(i), lv[i])
        srcFlag <= 18'h3FFFF;
        doWrite(`SOURCE_ENABLE_OFF, 32'h0003FFFF, 4'hF, 2'h0);
        repeat (2) @(posedge core_clk);
        `CHECK_EQ("request all", expReq(18'h3FFFF, 18'h3FFFF), srcRequest)
        srcFlag <= 18'h3C3C3;
        doWrite(`SOURCE_ENABLE_OFF, 32'h0002AAAA, 4'hF, 2'h0);
        repeat (2) @(posedge core_clk);
        `CHECK_EQ("request mixed", expReq(18'h3C3C3, 18'h2AAAA), srcRequest)
        checkRead("request status", `REQUEST_STATUS_OFF, {14'h0000, expReq(18'h3C3C3, 18'h2AAAA)}, 2'h0);
        doWrite(ADDR[0], 32'h00000000, 4'h1, 2'h0);
        checkRead("byte lane", ADDR[0], {16'h0000, PAT[0] & 16'hFF00}, 2'h0);
        doWrite(8'h1C, 32'hFFFFFFFF, 4'hF, 2'h2);
        checkRead("unmapped", 8'h1C, 32'h00000000, 2'h2);
        applyReset(2);
        for (int r = 0; r < 5; r++) checkRead("prio rereset", ADDR[r], {16'h0000, 16'h4444 & IMPL[r]}, 2'h0);
        for (int i = 0; i < 18; i++) `CHECK_EQ("level rereset", 3'h4, lv[i])
        `CHECK_EQ("request rereset", 18'h00000, srcRequest)
        summarize();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        summarize();
    end

endmodule // interrupt_priority_level_regs_tb

`default_nettype wire

/* inc/interrupt_priority_pkg.sv */
// types shared by the priority register bank
package interrupt_priority_pkg;

    localparam int SOURCES = 18;
    localparam int PRIO_REGS = 5;

    typedef logic [2:0]  level_t;
    typedef logic [15:0] prio_word_t;

    typedef struct packed {
        prio_word_t [PRIO_REGS-1:0] prio;
        logic [SOURCES-1:0]         enable;
        logic [SOURCES-1:0]         request;
        logic                       awHeld;
        logic [7:0]                 awAddr;
        logic                       wHeld;
        logic [31:0]                wData;
        logic [3:0]                 wStrb;
        logic                       bValid;
        logic [1:0]                 bResp;
        logic                       rValid;
        logic [31:0]                rData;
        logic [1:0]                 rResp;
    } state_s;

endpackage

/* inc/interrupt_priority_regs.svh */
// register offsets, field positions and reset values of the priority bank
`ifndef INTERRUPT_PRIORITY_REGS_SVH
`define INTERRUPT_PRIORITY_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PRIORITY_TIMER1_OC1_IC1_EXT0_OFF 8'h00
`define PRIORITY_TIMER2_OC2_IC2_DMA0_OFF 8'h04
`define PRIORITY_UART1RX_SPI1_TIMER3_OFF 8'h08
`define PRIORITY_DMA1_ADC1_UART1TX_OFF   8'h0C
`define PRIORITY_PINCHANGE_I2C1_OFF      8'h10
`define SOURCE_ENABLE_OFF                8'h14
`define REQUEST_STATUS_OFF               8'h18

// ****************************************
// implemented bits and power-on values
// ****************************************
`define PRIO_IMPL_MASK_0 16'h7777
`define PRIO_IMPL_MASK_1 16'h7777
`define PRIO_IMPL_MASK_2 16'h7777
`define PRIO_IMPL_MASK_3 16'h0777
`define PRIO_IMPL_MASK_4 16'h7077
`define PRIO_RESET_PATTERN 16'h4444
`define SOURCE_ENABLE_RESET 18'h00000

// ****************************************
// field positions (low bit of each level)
// ****************************************
`define UPPER_FIELD_POS 4'hC
`define MIDUP_FIELD_POS 4'h8
`define MIDLO_FIELD_POS 4'h4
`define LOWER_FIELD_POS 4'h0

// ****************************************
// bus answers
// ****************************************
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* logic/interrupt_priority_level_regs.sv */
// priority level register bank with source enables and request gating
//
// Behaviour
// - code 111 in a priority field means level seven, the highest.
// - code 001 means level one; codes between map to levels two to six.
// - code 000 disables the source; it never requests service.
// - unimplemented bits read zero and ignore writes.
// - after reset every implemented field holds 100, level four.
// - word 0: timer1 14-12, compare1 10-8, capture1 6-4, ext0 2-0.
// - word 1: timer2, compare2, capture2 upper fields, dma0 in 2-0.
// - word 2: uart1 rx 14-12, spi1 event 10-8, spi1 error 6-4, timer3 2-0.
// - word 3: 15-11 unused, dma1 10-8, adc1 6-4, uart1 tx 2-0.
// - word 4: pin change 14-12, 11-7 unused, i2c1 master 6-4, slave 2-0.
// - a per-source enable bit permits (1) or blocks (0) the request.
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_priority_regs.svh"

module interrupt_priority_level_regs
    import interrupt_priority_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_awaddr,
    input  wire logic [2:0]   s_axi_awprot,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    output logic [1:0]        s_axi_bresp,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    input  wire logic [31:0]  s_axi_araddr,
    input  wire logic [2:0]   s_axi_arprot,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    input  wire logic [17:0]  srcFlag,
    output logic [17:0]       srcRequest,
    output logic [2:0]        timer1_level,
    output logic [2:0]        out_compare1_level,
    output logic [2:0]        in_capture1_level,
    output logic [2:0]        ext_irq0_level,
    output logic [2:0]        timer2_level,
    output logic [2:0]        out_compare2_level,
    output logic [2:0]        in_capture2_level,
    output logic [2:0]        dma_ch0_done_level,
    output logic [2:0]        uart1_receive_level,
    output logic [2:0]        spi1_event_level,
    output logic [2:0]        spi1_error_level,
    output logic [2:0]        timer3_level,
    output logic [2:0]        dma_ch1_done_level,
    output logic [2:0]        adc1_done_level,
    output logic [2:0]        uart1_transmit_level,
    output logic [2:0]        pin_change_level,
    output logic [2:0]        i2c1_master_level,
    output logic [2:0]        i2c1_slave_level
);

    // ****************************************
    // constant tables
    // ****************************************
    localparam prio_word_t [PRIO_REGS-1:0] IMPL_MASK = {
        `PRIO_IMPL_MASK_4, `PRIO_IMPL_MASK_3, `PRIO_IMPL_MASK_2,
        `PRIO_IMPL_MASK_1, `PRIO_IMPL_MASK_0};

    // register index of each source, source 0 = timer1
    localparam logic [SOURCES-1:0][2:0] FIELD_REG = {
        3'h4, 3'h4, 3'h4,
        3'h3, 3'h3, 3'h3,
        3'h2, 3'h2, 3'h2, 3'h2,
        3'h1, 3'h1, 3'h1, 3'h1,
        3'h0, 3'h0, 3'h0, 3'h0};

    localparam logic [SOURCES-1:0][3:0] FIELD_POS = {
        `LOWER_FIELD_POS, `MIDLO_FIELD_POS, `UPPER_FIELD_POS,
        `LOWER_FIELD_POS, `MIDLO_FIELD_POS, `MIDUP_FIELD_POS,
        `LOWER_FIELD_POS, `MIDLO_FIELD_POS, `MIDUP_FIELD_POS, `UPPER_FIELD_POS,
        `LOWER_FIELD_POS, `MIDLO_FIELD_POS, `MIDUP_FIELD_POS, `UPPER_FIELD_POS,
        `LOWER_FIELD_POS, `MIDLO_FIELD_POS, `MIDUP_FIELD_POS, `UPPER_FIELD_POS};

    localparam state_s RESET_STATE = '{
        prio    : {`PRIO_IMPL_MASK_4 & `PRIO_RESET_PATTERN,
                   `PRIO_IMPL_MASK_3 & `PRIO_RESET_PATTERN,
                   `PRIO_IMPL_MASK_2 & `PRIO_RESET_PATTERN,
                   `PRIO_IMPL_MASK_1 & `PRIO_RESET_PATTERN,
                   `PRIO_IMPL_MASK_0 & `PRIO_RESET_PATTERN},
        enable  : `SOURCE_ENABLE_RESET,
        request : 18'h00000,
        awHeld  : 1'h0,
        awAddr  : 8'h00,
        wHeld   : 1'h0,
        wData   : 32'h00000000,
        wStrb   : 4'h0,
        bValid  : 1'h0,
        bResp   : `AXI_RESP_OKAY,
        rValid  : 1'h0,
        rData   : 32'h00000000,
        rResp   : `AXI_RESP_OKAY};

    state_s st_q;
    state_s st_d;
    level_t [SOURCES-1:0] level;
    logic   [SOURCES-1:0] levelLive;

    // ****************************************
    // level extraction
    // ****************************************
    always_comb begin
        for (int i = 0; i < SOURCES; i++) begin
            level[i] = st_q.prio[FIELD_REG[i]][FIELD_POS[i] +: 3];
            levelLive[i] = (level[i] != 3'h0);
        end
    end

    // ****************************************
    // register read decode
    // ****************************************
    function automatic logic [32:0] read_word(input logic [7:0] addr, input state_s s);
        logic [32:0] res;
        res = {1'b0, 32'h00000000};
        case (addr)
            `PRIORITY_TIMER1_OC1_IC1_EXT0_OFF: res = {1'b0, 16'h0000, s.prio[0]};
            `PRIORITY_TIMER2_OC2_IC2_DMA0_OFF: res = {1'b0, 16'h0000, s.prio[1]};
            `PRIORITY_UART1RX_SPI1_TIMER3_OFF: res = {1'b0, 16'h0000, s.prio[2]};
            `PRIORITY_DMA1_ADC1_UART1TX_OFF:   res = {1'b0, 16'h0000, s.prio[3]};
            `PRIORITY_PINCHANGE_I2C1_OFF:      res = {1'b0, 16'h0000, s.prio[4]};
            `SOURCE_ENABLE_OFF:                res = {1'b0, 14'h0000, s.enable};
            `REQUEST_STATUS_OFF:               res = {1'b0, 14'h0000, s.request};
            default:                           res = {1'b1, 32'h00000000};
        endcase
        return res;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] byteMask;
        logic [32:0] rd;
        logic [15:0] merged;
        logic        hit;
        byteMask = 32'h00000000;
        rd = {1'b0, 32'h00000000};
        merged = 16'h0000;
        hit = 1'b0;
        st_d = st_q;

        s_axi_awready = !st_q.awHeld && !st_q.bValid;
        s_axi_wready  = !st_q.wHeld && !st_q.bValid;
        s_axi_arready = !st_q.rValid;

        if (s_axi_awvalid && s_axi_awready) begin
            st_d.awHeld = 1'b1;
            st_d.awAddr = {s_axi_awaddr[7:2], 2'h0};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.wHeld = 1'b1;
            st_d.wData = s_axi_wdata;
            st_d.wStrb = s_axi_wstrb;
        end

        // write once address and data are both held
        if (st_q.awHeld && st_q.wHeld && !st_q.bValid) begin
            for (int b = 0; b < 4; b++) begin
                byteMask[b*8 +: 8] = {8{st_q.wStrb[b]}};
            end
            for (int k = 0; k < PRIO_REGS; k++) begin
                if (st_q.awAddr == 8'(k * 4)) begin
                    hit = 1'b1;
                    merged = (st_q.prio[k] & ~byteMask[15:0]) | (st_q.wData[15:0] & byteMask[15:0]);
                    st_d.prio[k] = merged & IMPL_MASK[k];
                end
            end
            if (st_q.awAddr == `SOURCE_ENABLE_OFF) begin
                hit = 1'b1;
                st_d.enable = (st_q.enable & ~byteMask[17:0]) | (st_q.wData[17:0] & byteMask[17:0]);
            end
            if (st_q.awAddr == `REQUEST_STATUS_OFF) begin
                hit = 1'b1;
            end
            st_d.awHeld = 1'b0;
            st_d.wHeld  = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp  = hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end
        if (st_q.bValid && s_axi_bready) begin
            st_d.bValid = 1'b0;
        end

        // read path
        if (s_axi_arvalid && s_axi_arready) begin
            rd = read_word({s_axi_araddr[7:2], 2'h0}, st_q);
            st_d.rValid = 1'b1;
            st_d.rData  = rd[31:0];
            st_d.rResp  = rd[32] ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
        end
        if (st_q.rValid && s_axi_rready) begin
            st_d.rValid = 1'b0;
        end

        // request gating by enable and nonzero level
        st_d.request = srcFlag & st_q.enable & levelLive;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_q <= RESET_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_bvalid = st_q.bValid;
    assign s_axi_bresp  = st_q.bResp;
    assign s_axi_rvalid = st_q.rValid;
    assign s_axi_rdata  = st_q.rData;
    assign s_axi_rresp  = st_q.rResp;
    assign srcRequest   = st_q.request;

    assign timer1_level         = level[0];
    assign out_compare1_level   = level[1];
    assign in_capture1_level    = level[2];
    assign ext_irq0_level       = level[3];
    assign timer2_level         = level[4];
    assign out_compare2_level   = level[5];
    assign in_capture2_level    = level[6];
    assign dma_ch0_done_level   = level[7];
    assign uart1_receive_level  = level[8];
    assign spi1_event_level     = level[9];
    assign spi1_error_level     = level[10];
    assign timer3_level         = level[11];
    assign dma_ch1_done_level   = level[12];
    assign adc1_done_level      = level[13];
    assign uart1_transmit_level = level[14];
    assign pin_change_level     = level[15];
    assign i2c1_master_level    = level[16];
    assign i2c1_slave_level     = level[17];

    // ****************************************
    // assertions
    // ****************************************
    logic       wrFire;
    logic       fullStrobe;
    logic [7:0] wrAddr;
    assign wrFire     = st_q.awHeld && st_q.wHeld && !st_q.bValid;
    assign fullStrobe = (st_q.wStrb[1:0] == 2'h3);
    assign wrAddr     = st_q.awAddr;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    top_level_req_a: assert property (
        (timer1_level == 3'h7) && srcFlag[0] && st_q.enable[0] |=> srcRequest[0])
        else $error("level seven source did not request");

    low_level_req_a: assert property (
        (ext_irq0_level == 3'h1) && srcFlag[3] && st_q.enable[3] |=> srcRequest[3])
        else $error("level one source did not request");

    disabled_source_a: assert property (
        1'b1 |=> ((srcRequest & ~$past(levelLive)) == 18'h00000))
        else $error("source with level zero requested");

    unimpl_bits_zero_a: assert property (
        s_axi_rvalid && (s_axi_rresp == `AXI_RESP_OKAY) |-> (s_axi_rdata[31:18] == 14'h0000))
        else $error("upper read bits not zero");

    reset_levels_a: assert property (@(posedge core_clk) disable iff (1'b0)
        !nrst |=> (st_q.prio[0] == 16'h4444) && (st_q.prio[1] == 16'h4444) && (st_q.prio[2] == 16'h4444)
            && (st_q.prio[3] == 16'h0444) && (st_q.prio[4] == 16'h4044))
        else $error("reset levels wrong");

    word0_layout_a: assert property (
        wrFire && fullStrobe && (wrAddr == `PRIORITY_TIMER1_OC1_IC1_EXT0_OFF)
        |=> (timer1_level == $past(st_q.wData[14:12])) && (ext_irq0_level == $past(st_q.wData[2:0])))
        else $error("word 0 fields misplaced");

    word1_layout_a: assert property (
        wrFire && fullStrobe && (wrAddr == `PRIORITY_TIMER2_OC2_IC2_DMA0_OFF)
        |=> (timer2_level == $past(st_q.wData[14:12])) && (dma_ch0_done_level == $past(st_q.wData[2:0])))
        else $error("word 1 fields misplaced");

    word2_layout_a: assert property (
        wrFire && fullStrobe && (wrAddr == `PRIORITY_UART1RX_SPI1_TIMER3_OFF)
        |=> (uart1_receive_level == $past(st_q.wData[14:12])) && (spi1_error_level == $past(st_q.wData[6:4])))
        else $error("word 2 fields misplaced");

    word3_layout_a: assert property (
        wrFire && fullStrobe && (wrAddr == `PRIORITY_DMA1_ADC1_UART1TX_OFF)
        |=> (st_q.prio[3][15:11] == 5'h00) && (dma_ch1_done_level == $past(st_q.wData[10:8])))
        else $error("word 3 fields misplaced");

    word4_layout_a: assert property (
        wrFire && fullStrobe && (wrAddr == `PRIORITY_PINCHANGE_I2C1_OFF)
        |=> (st_q.prio[4][11:7] == 5'h00) && (pin_change_level == $past(st_q.wData[14:12])))
        else $error("word 4 fields misplaced");

    enable_gate_a: assert property (
        1'b1 |=> ((srcRequest & ~$past(st_q.enable)) == 18'h00000))
        else $error("disabled source requested");

    word_write_read_a: assert property (
        wrFire && fullStrobe && (wrAddr == `PRIORITY_TIMER1_OC1_IC1_EXT0_OFF)
        |=> (st_q.prio[0] == ($past(st_q.wData[15:0]) & 16'h7777)) ##1 (st_q.prio[0] == $past(st_q.prio[0])))
        else $error("word write not stored whole");

    zero_level_block_a: assert property (
        (dma_ch0_done_level == 3'h0) |=> !srcRequest[7])
        else $error("zero level source requested");

    unimpl_held_zero_a: assert property (
        1'b1 |-> ((st_q.prio & ~IMPL_MASK) == '0))
        else $error("unimplemented priority bit set");

    write_answer_a: assert property (
        wrFire |=> s_axi_bvalid)
        else $error("write answer missing");

    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");

    write_refuse_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");

    read_refuse_a: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");

    reset_outputs_a: assert property (@(posedge core_clk) disable iff (1'b0)
        !nrst |=> (srcRequest == 18'h00000) && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not cleared by reset");

endmodule // interrupt_priority_level_regs

`default_nettype wire
